// ---- core/vbr_pkg.sv ----
package vbr_pkg;

  // ------------------------------------------------------------
  // register addresses (read and write spaces are separate)
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_IDENT_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_STATUS_TRIG  = 3'h1;
  localparam logic [2:0] ADDR_HIGH_CMD     = 3'h2;
  localparam logic [2:0] ADDR_LOW_DRACK    = 3'h3;
  localparam logic [2:0] ADDR_PARAM        = 3'h6;
  localparam logic [2:0] ADDR_DONEACK      = 3'h7;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ST_DRDY  = 0;
  localparam int ST_BUSY  = 1;
  localparam int ST_VMC   = 2;
  localparam int ST_ERR   = 3;
  localparam int ST_DONE  = 4;
  localparam int ST_APER  = 6;
  localparam int CT_IEN   = 0;
  localparam int CT_RST   = 1;
  localparam int CT_LSEL  = 2;
  localparam int CT_SRC   = 3;
  localparam int TR_EN    = 0;
  localparam int TR_FALL  = 1;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [3:0]  CTRL_RST_VAL   = 4'h0;
  localparam logic [1:0]  TRIG_RST_VAL   = 2'h0;
  localparam logic [15:0] WORD_RST_VAL   = 16'h0000;
  localparam int          CLK_MHZ        = 200;
  localparam int          SOFT_RST_US    = 500;
  localparam int          SOFT_RST_CYC   = SOFT_RST_US * CLK_MHZ;
  localparam int          FIFO_W         = 34;
  localparam int          FIFO_D         = 32;

  typedef enum logic [2:0] {
    VBR_IDLE  = 3'b001,
    VBR_RESET = 3'b010,
    VBR_WAIT  = 3'b100
  } vbr_rst_state_t;

endpackage : vbr_pkg

// ---- core/vbr_sync.sv ----
`timescale 1ns/10ps
module vbr_sync #(
  parameter int W = 1
) (
  input  wire logic         i_core_clk, // clock
  input  wire logic         i_rst,      // async reset
  input  wire logic [W-1:0] i_async,    // outside level
  output logic      [W-1:0] o_sync      // synchronised level
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : vbr_sync

// ---- core/vbr_fifo.sv ----
`timescale 1ns/10ps
module vbr_fifo #(
  parameter int W = 34,
  parameter int D = 32
) (
  input  wire logic         i_core_clk, // clock
  input  wire logic         i_rst,      // async reset
  input  wire logic         i_flush,    // drop contents
  input  wire logic         i_valid,    // write valid
  output logic              o_ready,    // not full
  input  wire logic [W-1:0] i_data,     // write data
  output logic              o_valid,    // not empty
  input  wire logic         i_ready,    // read accept
  output logic      [W-1:0] o_data      // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q;
  wire push = i_valid && o_ready;
  wire pop  = o_valid && i_ready;
  assign o_ready = (cnt_q != (AW+1)'(D));
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem_q[rp_q];
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_data;
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + AW'(1);
      if (pop)  rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : vbr_fifo

// ---- core/vbr_regs.sv ----
`timescale 1ns/10ps
// What this block does
// - identity register gives fixed eight-bit code
// - data ready set on reading, cleared on removal
// - new reading may overwrite unread data
// - busy set on command/parameter write, cleared when done
// - run-up complete flag, cleared by acknowledge
// - error flag; data registers hold error code
// - done cleared on command write, set on completion
// - aperiodic timing bit, forced by autorange multi-read
// - high word bits 31:16, low word 15:0
// - control register uses only low four bits
// - control bit 0 gates all interrupts
// - control bit 1 resets; 500 us after clear
// - control bit 2 picks interrupt line
// - control bit 3 adds run-up complete source
// - trigger bit 0 gates triggers
// - trigger bit 1 selects edge and line
// - command write sets mode and function
// - write to register 3 clears data ready
// - parameter register qualifies the command
// - write to register 7 clears run-up complete
// - acknowledge every transfer, never hold acknowledge
module vbr_regs
  import vbr_pkg::*;
#(
  parameter int          RST_WAIT_CYC = SOFT_RST_CYC, // soft-reset wait
  parameter logic [7:0]  IDENT_CODE   = 8'h5a          // arbitrary identity value
) (
  input  wire logic        i_core_clk,         // clock
  input  wire logic        i_rst,              // async reset
  // backplane side
  input  wire logic        i_bp_sel,           // slot select, from pin
  input  wire logic        i_bp_wr,            // 1 write, 0 read, from pin
  input  wire logic [2:0]  i_bp_addr,          // register number, from pin
  input  wire logic [15:0] i_bp_wdata,         // write data, from pin
  output logic      [15:0] o_bp_rdata,         // read data
  output logic             o_transfer_acknowledge_line,    // ack pulse
  output logic             o_general_purpose_irq_line,     // irq
  output logic             o_normal_scan_irq_line,         // irq
  input  wire logic        i_trigger_line,     // backplane trigger, pin
  input  wire logic        i_relay_close_strobe_line,      // relay_close_strobe_line, pin
  // converter side
  output logic      [15:0] o_cmd_word,         // last command
  output logic      [15:0] o_param_word,       // last parameter
  output logic             o_cmd_strobe,       // pulse on command write
  output logic             o_param_strobe,     // pulse on parameter write
  output logic             o_trig_pulse,       // accepted trigger
  output logic             o_conv_reset,       // converter held in reset
  input  wire logic        i_cmd_done,         // pulse: last command executed
  input  wire logic        i_runup_done,       // pulse: integrator run-up end
  input  wire logic        i_rd_valid,         // reading valid
  output logic             o_rd_ready,         // reading accepted
  input  wire logic [31:0] i_rd_data,          // reading or error code
  input  wire logic        i_rd_error,         // word is an error code
  input  wire logic        i_rd_aperiodic,     // sample timing slipped
  input  wire logic        i_autorange,        // autorange active
  input  wire logic        i_multi_read        // n readings per trigger
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic        sel_s, wr_s, trg_s, cls_s;
  logic [2:0]  addr_s;
  logic [15:0] wd_s;
  vbr_sync #(.W(23)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_bp_sel, i_bp_wr, i_bp_addr, i_bp_wdata, i_trigger_line,
                  i_relay_close_strobe_line}),
    .o_sync     ({sel_s, wr_s, addr_s, wd_s, trg_s, cls_s})
  );

  // ------------------------------------------------------------
  // transfer detect
  // ------------------------------------------------------------
  // one strobe per select so a long bus cycle acts once
  logic sel_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) sel_q <= 1'b0;
    else       sel_q <= sel_s;
  end
  wire xfer   = sel_s && !sel_q;
  wire wr_stb = xfer && wr_s;
  wire rd_stb = xfer && !wr_s;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    return a == r;
  endfunction : hit

  wire wr_ctrl  = wr_stb && hit(addr_s, ADDR_IDENT_CTRL);
  wire wr_trig  = wr_stb && hit(addr_s, ADDR_STATUS_TRIG);
  wire wr_cmd   = wr_stb && hit(addr_s, ADDR_HIGH_CMD);
  wire wr_drack = wr_stb && hit(addr_s, ADDR_LOW_DRACK);
  wire wr_par   = wr_stb && hit(addr_s, ADDR_PARAM);
  wire wr_vack  = wr_stb && hit(addr_s, ADDR_DONEACK);
  wire wr_any_cmd = wr_cmd || wr_par;

  // ------------------------------------------------------------
  // write registers
  // ------------------------------------------------------------
  logic [3:0]  ctrl_q;
  logic [1:0]  trig_q;
  logic [15:0] cmd_q, par_q;
  logic        cmd_stb_q, par_stb_q;
  // only the low bits are stored; the rest of each word is dropped
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RST_VAL;
      trig_q <= TRIG_RST_VAL;
    end else begin
      if (wr_ctrl) ctrl_q <= wd_s[3:0];
      if (wr_trig) trig_q <= wd_s[1:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q <= WORD_RST_VAL;
      par_q <= WORD_RST_VAL;
    end else begin
      if (wr_cmd) cmd_q <= wd_s;
      if (wr_par) par_q <= wd_s;
    end
  end

  // strobes line up with the acknowledge so the converter sees a
  // command only once the backplane has finished the write
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_stb_q <= 1'b0;
      par_stb_q <= 1'b0;
    end else begin
      cmd_stb_q <= wr_cmd;
      par_stb_q <= wr_par;
    end
  end
  assign o_cmd_word     = cmd_q;
  assign o_param_word   = par_q;
  assign o_cmd_strobe   = cmd_stb_q;
  assign o_param_strobe = par_stb_q;

  // ------------------------------------------------------------
  // soft reset sequencing
  // ------------------------------------------------------------
  // busy stays set until the wait ends so the controller can poll it
  vbr_rst_state_t rst_st_q, rst_st_d;
  logic [31:0]    rst_cnt_q;
  wire            rst_wait_end = (rst_cnt_q == 32'(RST_WAIT_CYC - 1));
  always_comb begin
    rst_st_d = rst_st_q;
    case (rst_st_q)
      VBR_IDLE:  if (ctrl_q[CT_RST]) rst_st_d = VBR_RESET;
      VBR_RESET: if (!ctrl_q[CT_RST]) rst_st_d = VBR_WAIT;
      VBR_WAIT: begin
        if (ctrl_q[CT_RST])    rst_st_d = VBR_RESET;
        else if (rst_wait_end) rst_st_d = VBR_IDLE;
      end
      default: rst_st_d = VBR_IDLE;
    endcase
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_st_q  <= VBR_IDLE;
      rst_cnt_q <= 32'h0000_0000;
    end else begin
      rst_st_q  <= rst_st_d;
      rst_cnt_q <= (rst_st_q == VBR_WAIT) ? rst_cnt_q + 32'h1 : 32'h0000_0000;
    end
  end
  wire soft_rst = (rst_st_q != VBR_IDLE);
  assign o_conv_reset = soft_rst;

  // ------------------------------------------------------------
  // reading path
  // ------------------------------------------------------------
  // the fifo buffers readings from the converter; the data registers
  // take the newest word whenever one is available, overwriting
  logic        f_valid;
  logic [33:0] f_data;
  vbr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_flush    (soft_rst),
    .i_valid    (i_rd_valid),
    .o_ready    (o_rd_ready),
    .i_data     ({i_rd_error, i_rd_aperiodic, i_rd_data}),
    .o_valid    (f_valid),
    .i_ready    (1'b1),
    .o_data     (f_data)
  );

  logic [31:0] data_q;
  logic        drdy_q, busy_q, vmc_q, err_q, done_q, aper_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      data_q <= 32'h0000_0000;
      drdy_q <= 1'b0;
      err_q  <= 1'b0;
      aper_q <= 1'b0;
    end else if (soft_rst) begin
      data_q <= 32'h0000_0000;
      drdy_q <= 1'b0;
      err_q  <= 1'b0;
      aper_q <= 1'b0;
    end else begin
      if (f_valid) begin
        data_q <= f_data[31:0];
        err_q  <= f_data[33];
        aper_q <= f_data[32];
      end
      // set wins over an acknowledge in the same cycle
      if (f_valid)       drdy_q <= 1'b1;
      else if (wr_drack) drdy_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // command handshake and run-up flags
  // ------------------------------------------------------------
  // completions are dropped while the soft reset is in force, so a late
  // pulse from an aborted command cannot report success
  wire cmd_fin = i_cmd_done && !soft_rst;
  wire run_fin = i_runup_done && !soft_rst;

  // a command write in the cycle of a completion leaves busy set,
  // since that completion belongs to the older command
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
    end else if (wr_any_cmd) begin
      busy_q <= 1'b1;
    end else if (cmd_fin) begin
      busy_q <= 1'b0;
    end
  end

  // the completion wins over a write in the same cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else if (cmd_fin) begin
      done_q <= 1'b1;
    end else if (wr_any_cmd) begin
      done_q <= 1'b0;
    end
  end

  // set wins over the acknowledge; a soft reset drops the flag
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      vmc_q <= 1'b0;
    end else if (run_fin) begin
      vmc_q <= 1'b1;
    end else if (wr_vack || soft_rst) begin
      vmc_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // status byte
  // ------------------------------------------------------------
  // bits 5 and 7 carry nothing and read zero; busy also covers the
  // soft reset wait so polling busy tells when the reset is over
  wire        aper_bit = aper_q || (i_autorange && i_multi_read);
  wire        busy_bit = busy_q || soft_rst;
  logic [7:0] status;
  always_comb begin
    status          = 8'h00;
    status[ST_DRDY] = drdy_q;
    status[ST_BUSY] = busy_bit;
    status[ST_VMC]  = vmc_q;
    status[ST_ERR]  = err_q;
    status[ST_DONE] = done_q;
    status[ST_APER] = aper_bit;
  end

  // ------------------------------------------------------------
  // triggers
  // ------------------------------------------------------------
  logic trg_q, cls_q, tp_q;
  wire  fall_trg = trg_q && !trg_s;
  wire  rise_cls = cls_s && !cls_q;
  wire  edge_sel = trig_q[TR_FALL] ? fall_trg : rise_cls;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      trg_q <= 1'b0;
      cls_q <= 1'b0;
      tp_q  <= 1'b0;
    end else begin
      trg_q <= trg_s;
      cls_q <= cls_s;
      tp_q  <= trig_q[TR_EN] && edge_sel && !soft_rst;
    end
  end
  assign o_trig_pulse = tp_q;

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  wire irq_src = drdy_q || (ctrl_q[CT_SRC] && vmc_q);
  wire irq     = ctrl_q[CT_IEN] && irq_src;
  logic gen_irq_q, scan_irq_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gen_irq_q  <= 1'b0;
      scan_irq_q <= 1'b0;
    end else begin
      gen_irq_q  <= irq && !ctrl_q[CT_LSEL];
      scan_irq_q <= irq &&  ctrl_q[CT_LSEL];
    end
  end
  assign o_general_purpose_irq_line = gen_irq_q;
  assign o_normal_scan_irq_line     = scan_irq_q;

  // ------------------------------------------------------------
  // read mux and acknowledge
  // ------------------------------------------------------------
  logic [15:0] rsel;
  always_comb begin
    case (addr_s)
      ADDR_IDENT_CTRL:  rsel = {8'h00, IDENT_CODE};
      ADDR_STATUS_TRIG: rsel = {8'h00, status};
      ADDR_HIGH_CMD:    rsel = data_q[31:16];
      ADDR_LOW_DRACK:   rsel = data_q[15:0];
      default:          rsel = 16'h0000;
    endcase
  end
  logic [15:0] rd_q;
  logic        ack_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_q  <= 16'h0000;
      ack_q <= 1'b0;
    end else begin
      if (rd_stb) rd_q <= rsel;
      ack_q <= xfer;
    end
  end
  assign o_bp_rdata                  = rd_q;
  assign o_transfer_acknowledge_line = ack_q;
endmodule : vbr_regs

// ---- verif/vbr_regs_asserts.sv ----
`timescale 1ns/10ps
module vbr_regs_asserts
  import vbr_pkg::*;
(
  input wire logic        i_core_clk,                  // clock
  input wire logic        i_rst,                       // reset
  input wire logic        i_bp_sel,                    // select
  input wire logic        i_bp_wr,                     // direction
  input wire logic [2:0]  i_bp_addr,                   // register
  input wire logic [15:0] i_bp_wdata,                  // write data
  input wire logic [15:0] o_bp_rdata,                  // read data
  input wire logic        o_transfer_acknowledge_line, // ack
  input wire logic        o_general_purpose_irq_line,  // irq
  input wire logic        o_normal_scan_irq_line,      // irq
  input wire logic [15:0] o_cmd_word,                  // command
  input wire logic        o_cmd_strobe,                // strobe
  input wire logic        o_trig_pulse                 // trigger
);
  // ----------------------------------------
  // backplane and converter-side checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  wire logic ack;
  wire logic rd_ack;
  assign ack = o_transfer_acknowledge_line;
  assign rd_ack = ack && !i_bp_wr;

  AST_ACK_ONE: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  AST_ACK_DUE: assert property ($rose(i_bp_sel) |-> ##[2:6] ack)
    else $error("transfer not acknowledged in time");
  AST_CMD_ACK: assert property (o_cmd_strobe |-> ack && i_bp_wr && i_bp_addr == ADDR_HIGH_CMD)
    else $error("command strobe without command write");
  AST_CMD_WORD: assert property (o_cmd_strobe |-> o_cmd_word == i_bp_wdata)
    else $error("command word differs from written value");
  AST_CMD_HOLD: assert property (!o_cmd_strobe |-> $stable(o_cmd_word))
    else $error("command word moved without a write");
  AST_UNUSED_ZERO: assert property (rd_ack && i_bp_addr[2] |-> o_bp_rdata == 16'h0000)
    else $error("unused register read not zero");
  AST_STATUS_SPARE: assert property (rd_ack && i_bp_addr == ADDR_STATUS_TRIG |->
    o_bp_rdata[15:7] == 9'h000 && !o_bp_rdata[5]) else $error("spare status bits set");
  AST_ONE_LINE: assert property (!(o_general_purpose_irq_line && o_normal_scan_irq_line))
    else $error("both interrupt lines raised");
  AST_TRIG_ONE: assert property (o_trig_pulse |=> !o_trig_pulse)
    else $error("trigger pulse longer than one cycle");
  cover property (o_cmd_strobe);
  cover property (o_trig_pulse);
  cover property (o_general_purpose_irq_line);
  cover property (o_normal_scan_irq_line);
endmodule : vbr_regs_asserts

bind vbr_regs vbr_regs_asserts u_chk (.*);

// ---- verif/vbr_host_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// controller: one transfer per select rise
// ----------------------------------------
module vbr_host_model (
  input  wire logic        i_core_clk, // clock
  input  wire logic        i_ack,      // acknowledge
  output logic             o_sel,      // select
  output logic             o_wr,       // direction
  output logic      [2:0]  o_addr,     // register
  output logic      [15:0] o_wdata     // write data
);
  initial {o_sel, o_wr, o_addr, o_wdata} = 21'h0;
  task automatic xfer(input logic w, input logic [2:0] a, input logic [15:0] d, output bit ok);
    int n;
    o_wr = w;
    o_addr = a;
    o_wdata = d;
    // pins settle a cycle before select so the sync flops see them together
    @(posedge i_core_clk);
    #1;
    o_sel = 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 30);
    ok = (i_ack === 1'b1);
    #1;
    o_sel = 1'b0;
    // released data shows the inverse so stale values never match
    o_wdata = ~d;
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask : xfer
endmodule : vbr_host_model

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb;
  import vbr_pkg::*;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  localparam logic [7:0] ID = 8'h3c; // arbitrary identity value
  localparam logic [2:0] ST = ADDR_STATUS_TRIG;
  localparam int WAITC = 20;
  logic clk, rst, ack, girq, sirq, trg, clo, cdone, runup, rvld, rerr, raper, autor, multi;
  logic sel, wr, cstb, pstb, rrdy, tpul, creset;
  logic [2:0] addr;
  logic [15:0] wdata, rdata, cword, pword, d;
  logic [31:0] rdat, rv;
  logic [15:0] exp_q[$];
  int mismatches, cmp_count, tcnt, scnt;

  vbr_regs #(.RST_WAIT_CYC(WAITC), .IDENT_CODE(ID)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_bp_sel(sel), .i_bp_wr(wr), .i_bp_addr(addr),
    .i_bp_wdata(wdata), .o_bp_rdata(rdata), .o_transfer_acknowledge_line(ack),
    .o_general_purpose_irq_line(girq), .o_normal_scan_irq_line(sirq), .i_trigger_line(trg),
    .i_relay_close_strobe_line(clo), .o_cmd_word(cword), .o_param_word(pword),
    .o_cmd_strobe(cstb), .o_param_strobe(pstb), .o_trig_pulse(tpul), .o_conv_reset(creset),
    .i_cmd_done(cdone), .i_runup_done(runup), .i_rd_valid(rvld), .o_rd_ready(rrdy),
    .i_rd_data(rdat), .i_rd_error(rerr), .i_rd_aperiodic(raper), .i_autorange(autor),
    .i_multi_read(multi));
  vbr_host_model u_host (.i_core_clk(clk), .i_ack(ack), .o_sel(sel), .o_wr(wr),
    .o_addr(addr), .o_wdata(wdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hold(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  task automatic bus(logic w, logic [2:0] a, logic [15:0] v);
    bit ok;
    if (!w) exp_q.push_back(v);
    u_host.xfer(w, a, w ? v : 16'($urandom), ok);
    if (!ok) begin
      chk("acknowledge", 16'h0001, 16'h0000);
      stop_test();
    end
  endtask : bus

  // valid stays up across a burst; the fifo drains every cycle
  task automatic push(int n, logic e, logic ap);
    rvld = 1'b1;
    rerr = e;
    raper = ap;
    for (int i = 0; i < n; i++) begin
      rv = $urandom;
      rdat = rv;
      hold(1);
    end
    rvld = 1'b0;
    rdat = ~rv;
    hold(6);
  endtask : push

  task automatic pulse(ref logic s);
    s = 1'b1;
    hold(1);
    s = 1'b0;
    hold(3);
  endtask : pulse

  always @(posedge clk) begin
    if (tpul === 1'b1) tcnt++;
    if (cstb === 1'b1) scnt += 1;
    if (pstb === 1'b1) scnt += 16;
    if (ack === 1'b1 && wr === 1'b0) begin
      if (exp_q.size() > 0) chk("read data", exp_q.pop_front(), rdata);
      else chk("read count", 16'h0000, 16'h0001);
    end
  end

  initial begin
    {rst, trg, clo, cdone, runup, rvld, rerr, raper, autor, multi} = 10'h200;
    rdat = 32'h0;
    mismatches = 0;
    cmp_count = 0;
    tcnt = 0;
    scnt = 0;
    void'($urandom(41170));
    hold(8);
    rst = 1'b0;
    hold(1);
    bus(0, ADDR_IDENT_CTRL, {8'h00, ID});
    bus(1, 3'h4, 16'h00ff);
    bus(1, 3'h5, 16'hffff);
    for (int a = 4; a < 8; a++) bus(0, 3'(a), 16'h0000);
    bus(0, ST, 16'h0000);
    $display("test identity and unused done");
    for (int i = 0; i < 2; i++) begin
      d = 16'($urandom);
      bus(1, i ? ADDR_PARAM : ADDR_HIGH_CMD, d);
      chk("command word", d, i ? pword : cword);
      bus(0, ST, 16'h0002);
      pulse(cdone);
      bus(0, ST, 16'h0010);
    end
    chk("strobe count", 16'h0011, 16'(scnt));
    $display("test command done");
    autor = 1'b1;
    multi = 1'b1;
    push(8, 1'b0, 1'b0);
    chk("fifo ready", 16'h0001, 16'(rrdy));
    bus(0, ST, 16'h0051);
    bus(0, ADDR_HIGH_CMD, rv[31:16]);
    bus(0, ADDR_LOW_DRACK, rv[15:0]);
    autor = 1'b0;
    push(1, 1'b0, 1'b0);
    bus(0, ST, 16'h0011);
    bus(1, ADDR_LOW_DRACK, 16'($urandom));
    bus(0, ST, 16'h0010);
    push(1, 1'b0, 1'b1);
    bus(0, ST, 16'h0051);
    push(1, 1'b1, 1'b0);
    bus(0, ST, 16'h0019);
    bus(0, ADDR_LOW_DRACK, rv[15:0]);
    bus(1, ADDR_LOW_DRACK, 16'h0000);
    $display("test readings done");
    bus(1, ADDR_IDENT_CTRL, 16'h00f1);
    push(1, 1'b0, 1'b0);
    chk("irq lines", 16'h0002, 16'({girq, sirq}));
    bus(1, ADDR_LOW_DRACK, 16'h0000);
    pulse(runup);
    chk("irq lines", 16'h0000, 16'({girq, sirq}));
    bus(0, ST, 16'h0014);
    bus(1, ADDR_IDENT_CTRL, 16'h000d);
    chk("irq lines", 16'h0001, 16'({girq, sirq}));
    bus(1, ADDR_IDENT_CTRL, 16'h000c);
    chk("irq lines", 16'h0000, 16'({girq, sirq}));
    bus(1, ADDR_DONEACK, 16'($urandom));
    bus(0, ST, 16'h0010);
    $display("test interrupts done");
    for (int i = 0; i < 3; i++) begin
      bus(1, ST, 16'({i != 0, i != 2}));
      tcnt = 0;
      pulse(clo);
      pulse(trg);
      pulse(trg);
      hold(4);
      chk("trigger count", 16'(i == 2 ? 0 : i + 1), 16'(tcnt));
    end
    $display("test trigger done");
    push(1, 1'b0, 1'b0);
    bus(1, ADDR_IDENT_CTRL, 16'h0002);
    chk("converter reset", 16'h0001, 16'(creset));
    bus(0, ST, 16'h0012);
    bus(0, ADDR_HIGH_CMD, 16'h0000);
    bus(1, ADDR_IDENT_CTRL, 16'h0000);
    hold(WAITC - 10);
    chk("converter reset", 16'h0001, 16'(creset));
    hold(14);
    chk("converter reset", 16'h0000, 16'(creset));
    bus(0, ST, 16'h0010);
    $display("test soft reset done");
    stop_test();
  end
endmodule : tb
